// ### pkg/kbd_enc_pkg.sv
package kbd_enc_pkg;

  // ----------------------------------------
  // table organisation
  // ----------------------------------------
  localparam int DRIVE_COUNT = 8;
  localparam int SENSE_COUNT = 11;
  localparam int BANK_WORDS = 88;
  localparam int BANK_COUNT = 3;
  localparam int TABLE_WORDS = 264;
  localparam int CODE_WIDTH = 9;
  localparam int DATA_WIDTH = 8;
  localparam int PARITY_POS = 8;
  localparam int ADDR_WIDTH = 9;

  // ----------------------------------------
  // reset values and encodings
  // ----------------------------------------
  localparam logic [7:0] DRIVE_RESET = 8'h01;
  localparam logic [10:0] SENSE_RESET = 11'h001;
  localparam logic [1:0] BANK_NORMAL = 2'h0;
  localparam logic [1:0] BANK_SHIFT = 2'h1;
  localparam logic [1:0] BANK_CONTROL = 2'h2;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int SCAN_HZ = 50_000;
  localparam int SCAN_DIV = CLK_HZ / SCAN_HZ;
  localparam int DEBOUNCE_SCANS = 16;

endpackage

// ### hw/kbd_code_table.sv
`timescale 1ns/1ps
module kbd_code_table (
  // lookup
  input wire logic [8:0] addr,
  output logic [8:0] code
);
  // ascii-like fill: shift bank offsets base code, control bank keeps low 5 bits of key index; bit 8 is odd parity over low 7 bits
  function automatic logic [8:0] entry(input logic [8:0] a);
    logic [7:0] d;
    d = 8'(a) + 8'h20;
    if (a >= 9'(kbd_enc_pkg::BANK_WORDS * 2)) begin
      d = 8'(a - 9'(kbd_enc_pkg::BANK_WORDS * 2)) & 8'h1F;
    end
    return {~^d[6:0], d};
  endfunction

  // constant table held as logic; out-of-range index reads zero
  always_comb begin
    code = 9'h000;
    if (addr < 9'(kbd_enc_pkg::TABLE_WORDS)) begin
      code = entry(addr);
    end
  end
endmodule

// ### hw/keyboard_matrix_encoder.sv
`timescale 1ns/1ps
// Notes on behaviour
// - a 264 by 9 code table in three banks of 88 words holds one code per key per mode.
// - the shift and control inputs pick which bank supplies the code.
// - the table address joins the bank with the drive and sense counter positions.
// - eight drive lines and eleven sense lines form the 88-key grid.
// - with no key down both counters keep stepping and the strobe stays inactive.
// - a sense line matching the sense counter position raises a match.
// - a match halts scanning, holds the code and then raises the strobe.
// - the code stays stable while the key is held and scanning resumes on release.
// - the strobe waits a settable delay after the match to mask contact bounce.
// - parity output is the stored bit, inverted when the parity invert input is high.
// - the eight data outputs are inverted when the data/strobe invert input is high.
// - the data/strobe invert input also flips the strobe polarity.
// - the table holds up to 264 codes of eight data bits plus parity.
// - the standard pattern gives 8-bit codes with odd parity over the low seven bits.
// - two-key rollover is given and other keys are locked out while one is encoded.
module keyboard_matrix_encoder #(
  parameter int SCAN_DIV = kbd_enc_pkg::SCAN_DIV,
  parameter int DEBOUNCE_SCANS = kbd_enc_pkg::DEBOUNCE_SCANS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // key matrix
  output logic [7:0] matrix_drive_lines,
  input wire logic [10:0] matrix_sense_lines,
  // mode and polarity
  input wire logic shift_in,
  input wire logic control_in,
  input wire logic parity_invert,
  input wire logic data_strobe_invert,
  // strobe delay, in scan clocks
  input wire logic [7:0] strobe_delay,
  // code out
  output logic [8:0] code_outputs,
  output logic strobe
);

  typedef enum logic [1:0] {SCANNING, DEBOUNCE, HELD} phase_t;

  typedef struct packed {
    logic [15:0] div;
    logic [7:0] drive;
    logic [10:0] sense;
    logic [3:0] drive_idx;
    logic [3:0] sense_idx;
    phase_t phase;
    logic [7:0] delay_cnt;
    logic [8:0] code;
    logic strobe_int;
    logic [8:0] code_out;
    logic strobe_out;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [1:0] bank;
  logic [8:0] addr;
  logic [8:0] rom_code;
  logic tick;
  logic hit;

  // ----------------------------------------
  // bank select and address
  // ----------------------------------------
  // control takes priority when both are high; that combination is not documented
  always_comb begin
    bank = kbd_enc_pkg::BANK_NORMAL;
    if (control_in) begin
      bank = kbd_enc_pkg::BANK_CONTROL;
    end else if (shift_in) begin
      bank = kbd_enc_pkg::BANK_SHIFT;
    end
    addr = 9'(32'(bank) * kbd_enc_pkg::BANK_WORDS
           + 32'(state_reg.drive_idx) * kbd_enc_pkg::SENSE_COUNT
           + 32'(state_reg.sense_idx));
  end

  kbd_code_table u_table (
    .addr(addr),
    .code(rom_code)
  );

  // a closed key joins the active drive line to one sense line
  assign hit = |(matrix_sense_lines & state_reg.sense) & (state_reg.drive != 8'h00);
  assign tick = (state_reg.div == 16'(SCAN_DIV - 1));

  // ----------------------------------------
  // scan, match, debounce and hold
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.div = tick ? 16'h0000 : state_reg.div + 16'h0001;
    case (state_reg.phase)
      SCANNING: begin
        state_next.strobe_int = 1'b0;
        if (hit) begin
          state_next.phase = DEBOUNCE;
          state_next.code = rom_code;
          state_next.delay_cnt = 8'h00;
        end else if (tick) begin
          // sense ring steps every tick, drive ring once per sense wrap
          state_next.sense = {state_reg.sense[9:0], state_reg.sense[10]};
          state_next.sense_idx = (state_reg.sense_idx == 4'hA) ? 4'h0 : state_reg.sense_idx + 4'h1;
          if (state_reg.sense[10]) begin
            state_next.drive = {state_reg.drive[6:0], state_reg.drive[7]};
            state_next.drive_idx = (state_reg.drive_idx == 4'h7) ? 4'h0 : state_reg.drive_idx + 4'h1;
          end
        end
      end
      DEBOUNCE: begin
        // a bounce open restarts the scan so no false code is strobed
        if (!hit) begin
          state_next.phase = SCANNING;
        end else if (tick) begin
          if (state_reg.delay_cnt >= strobe_delay) begin
            state_next.phase = HELD;
            state_next.strobe_int = 1'b1;
          end else begin
            state_next.delay_cnt = state_reg.delay_cnt + 8'h01;
          end
        end
      end
      HELD: begin
        // counters frozen: other keys are not seen until this one lifts
        if (!hit) begin
          state_next.phase = SCANNING;
          state_next.strobe_int = 1'b0;
        end
      end
      default: begin
        state_next.phase = SCANNING;
      end
    endcase
    // output polarity stage
    state_next.code_out = {state_next.code[8] ^ parity_invert,
                           state_next.code[7:0] ^ {8{data_strobe_invert}}};
    state_next.strobe_out = state_next.strobe_int ^ data_strobe_invert;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= '{div: 16'h0000, drive: kbd_enc_pkg::DRIVE_RESET, sense: kbd_enc_pkg::SENSE_RESET,
                     drive_idx: 4'h0, sense_idx: 4'h0, phase: SCANNING, delay_cnt: 8'h00,
                     code: 9'h000, strobe_int: 1'b0, code_out: 9'h000, strobe_out: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign matrix_drive_lines = state_reg.drive;
  assign code_outputs = state_reg.code_out;
  assign strobe = state_reg.strobe_out;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_match;
    state_reg.phase == SCANNING && hit;
  endsequence

  sequence s_frozen;
    $stable(state_reg.drive) && $stable(state_reg.sense);
  endsequence

  AST_HALT_ON_MATCH: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_match |=> s_frozen)
    else $error("counters moved after a match");

  AST_HELD_STABLE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_reg.phase == HELD && hit) |=> (s_frozen and $stable(state_reg.code)))
    else $error("held code or counters changed");

  AST_NO_STROBE_SCANNING: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_reg.phase == SCANNING) |-> !state_reg.strobe_int)
    else $error("strobe active while scanning");

  AST_STEP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_reg.phase == SCANNING && !hit && tick)
      |=> state_reg.sense == {$past(state_reg.sense[9:0]), $past(state_reg.sense[10])})
    else $error("scan did not step");

  AST_PARITY_POL: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !$past(sys_rst) |-> code_outputs[8] == (state_reg.code[8] ^ $past(parity_invert)))
    else $error("parity polarity wrong");

  AST_DATA_POL: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !$past(sys_rst) |-> code_outputs[7:0] == (state_reg.code[7:0] ^ {8{$past(data_strobe_invert)}}))
    else $error("data polarity wrong");

  AST_STROBE_POL: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_reg.phase == SCANNING && $past(state_reg.phase) == SCANNING)
      |-> strobe == $past(data_strobe_invert))
    else $error("strobe idle level wrong");

  AST_DELAY: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(state_reg.strobe_int) |-> $past(state_reg.delay_cnt) >= $past(strobe_delay) && $past(tick))
    else $error("strobe raised before delay");

  AST_ONE_DRIVE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $onehot(state_reg.drive) && $onehot(state_reg.sense))
    else $error("ring counter lost its single bit");

  // outside scanning the drive and sense rings hold, so a second key cannot be seen until the first lifts
  sequence s_idle;
    state_reg.phase == SCANNING && !state_reg.strobe_int;
  endsequence

  AST_LOCKOUT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_reg.phase != SCANNING) |=> s_frozen)
    else $error("counters moved while a key was encoded");

  AST_BOUNCE_RESTART: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_reg.phase == DEBOUNCE && !hit) |=> s_idle)
    else $error("bounce did not restart the scan");

  AST_RELEASE_RESUME: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_reg.phase == HELD && !hit) |=> s_idle)
    else $error("release did not resume the scan");

endmodule

// ### test/key_matrix_model.sv
`timescale 1ns/1ps
module key_matrix_model (
  // grid
  input wire logic [7:0] matrix_drive_lines,
  output logic [10:0] matrix_sense_lines,
  // two keys at most, each a drive row and a sense column
  input wire logic [1:0] key_down,
  input wire logic [2:0] row_a,
  input wire logic [3:0] col_a,
  input wire logic [2:0] row_b,
  input wire logic [3:0] col_b
);
  // ----------------------------------------
  // switch crosspoints
  // ----------------------------------------
  // open sense lines rest on their pull-down, so an idle grid reads zero
  logic hit_a;
  logic hit_b;
  assign hit_a = key_down[0] & matrix_drive_lines[row_a];
  assign hit_b = key_down[1] & matrix_drive_lines[row_b];
  assign matrix_sense_lines = ({11{hit_a}} & (11'h001 << col_a)) | ({11{hit_b}} & (11'h001 << col_b));
endmodule

// ### test/keyboard_matrix_encoder_test.sv
`timescale 1ns/1ps
module keyboard_matrix_encoder_test;
  // ----------------------------------------
  // clock, design and key grid
  // ----------------------------------------
  logic sys_clk = 1'b0;
  logic sys_rst, shift_in, control_in, parity_invert, data_strobe_invert, strobe;
  logic [7:0] matrix_drive_lines, strobe_delay;
  logic [10:0] matrix_sense_lines;
  logic [8:0] code_outputs, code_b;
  logic [8:0] codes [4];
  logic [1:0] key_down;
  logic [2:0] row_a, row_b;
  logic [3:0] col_a, col_b;
  int err_total = 0;
  int samples_checked = 0;
  int bad, n;
  always #12.5 sys_clk = ~sys_clk;
  // short scan divider keeps the run brief; expectations scale by 4
  keyboard_matrix_encoder #(.SCAN_DIV(4), .DEBOUNCE_SCANS(16)) i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .matrix_drive_lines(matrix_drive_lines), .matrix_sense_lines(matrix_sense_lines), .shift_in(shift_in),
    .control_in(control_in), .parity_invert(parity_invert), .data_strobe_invert(data_strobe_invert),
    .strobe_delay(strobe_delay), .code_outputs(code_outputs), .strobe(strobe));
  key_matrix_model i_keys (.matrix_drive_lines(matrix_drive_lines), .matrix_sense_lines(matrix_sense_lines),
    .key_down(key_down), .row_a(row_a), .col_a(col_a), .row_b(row_b), .col_b(col_b));
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // strobe level is judged after the polarity input is taken out
  task automatic wait_valid(input logic want);
    n = 0;
    while ((strobe ^ data_strobe_invert) !== want && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    check("strobe wait", 1'b1, n < 2000);
    if (n >= 2000) conclude();
  endtask
  task automatic expect_scan();
    logic [7:0] start;
    start = matrix_drive_lines;
    bad = 0;
    n = 0;
    while (matrix_drive_lines === start && n < 100) begin
      @(negedge sys_clk);
      n++;
      bad += (strobe !== data_strobe_invert);
    end
    check("drive steps", 1'b1, n < 100);
    check("idle strobe", 9'h000, 9'(bad));
    if (n >= 100) conclude();
  endtask
  task automatic press_read(input logic [2:0] r, input logic [3:0] c, output logic [8:0] code);
    row_a = r;
    col_a = c;
    key_down[0] = 1'b1;
    wait_valid(1'b1);
    // earliest strobe: strobe_delay whole ticks plus a partial one after the match
    check("delay floor", 1'b1, n > strobe_delay * 4);
    check("drive held", 8'h01 << r, matrix_drive_lines);
    code = code_outputs;
    check("parity", ~^code[6:0], code[8]);
    repeat (6) @(negedge sys_clk);
    check("code stable", code, code_outputs);
  endtask
  task automatic let_go();
    key_down = 2'b00;
    wait_valid(1'b0);
    check("strobe drop", 1'b1, n <= 3);
    expect_scan();
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    {sys_rst, shift_in, control_in, parity_invert, data_strobe_invert} = 5'h10;
    {key_down, row_a, col_a, row_b, col_b} = 16'h0000;
    strobe_delay = 8'h02;
    repeat (5) @(negedge sys_clk);
    sys_rst = 1'b0;
    check("reset drive", 9'h001, 9'(matrix_drive_lines));
    check("reset strobe", 9'h000, 9'(strobe));
    expect_scan();
    // every mode pairing; both high must read like control alone
    for (int m = 0; m < 4; m++) begin
      {control_in, shift_in} = m[1:0];
      press_read(3'h0, 4'h9, codes[m]);
      let_go();
    end
    check("both modes", codes[2], codes[3]);
    check("control bank", 9'h000, 9'(codes[2][7:5]));
    {control_in, shift_in} = 2'h0;
    strobe_delay = 8'h0a;
    press_read(3'h5, 4'h2, code_b);
    data_strobe_invert = 1'b1;
    repeat (2) @(negedge sys_clk);
    check("data flip", {code_b[8], ~code_b[7:0]}, code_outputs);
    check("strobe low", 9'h000, 9'(strobe));
    parity_invert = 1'b1;
    repeat (2) @(negedge sys_clk);
    check("parity flip", ~code_b, code_outputs);
    {parity_invert, data_strobe_invert} = 2'h0;
    // a second key while one is held is locked out, then read on release
    {row_b, col_b} = 7'h09;
    key_down[1] = 1'b1;
    repeat (40) @(negedge sys_clk);
    check("lockout", code_b, code_outputs);
    key_down[0] = 1'b0;
    wait_valid(1'b0);
    wait_valid(1'b1);
    check("rollover", codes[0], code_outputs);
    let_go();
    // a closure on the row now driven is matched at once but lifts before the long delay ends
    strobe_delay = 8'h20;
    {row_a, col_a} = 7'h10;
    key_down[0] = 1'b1;
    bad = 0;
    repeat (60) begin
      @(negedge sys_clk);
      bad += (strobe !== data_strobe_invert);
    end
    check("short frozen", 9'h002, 9'(matrix_drive_lines));
    check("short strobe", 9'h000, 9'(bad));
    key_down = 2'b00;
    expect_scan();
    conclude();
  end
endmodule
